// ===== verilog/sbst_pkg.sv
package sbst_pkg;

  // ----------------------------------------------------------------
  // Register sizes
  // ----------------------------------------------------------------
  localparam int IR_W = 3;
  localparam int BSR_W = 69;
  localparam int ID_W = 32;

  // ----------------------------------------------------------------
  // Instruction codes (the all-zero code is fixed; the rest are defaults of the top parameters)
  // ----------------------------------------------------------------
  localparam logic [2:0] INS_FLOAT_SAMPLE_ALL0 = 3'h0;
  localparam logic [2:0] INS_IDENT_DEF = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z_DEF = 3'h2;
  localparam logic [2:0] INS_RSVD_A_DEF = 3'h3;
  localparam logic [2:0] INS_SAMPLE_DEF = 3'h4;
  localparam logic [2:0] INS_RSVD_B_DEF = 3'h5;
  localparam logic [2:0] INS_RSVD_C_DEF = 3'h6;
  localparam logic [2:0] INS_BYPASS_DEF = 3'h7;

  // Arbitrary identity word, names no maker or part
  localparam logic [31:0] IDENT_WORD_DEF = 32'h0a5c_3001;

  // ----------------------------------------------------------------
  // Capture and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic BYPASS_CAPTURE_VAL = 1'b0;
  localparam int TMS_RESET_EDGES = 5;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_EXIT2_DR = 4'h0,
    ST_EXIT1_DR = 4'h1,
    ST_SHIFT_DR = 4'h2,
    ST_PAUSE_DR = 4'h3,
    ST_SEL_IR = 4'h4,
    ST_UPDATE_DR = 4'h5,
    ST_CAPTURE_DR = 4'h6,
    ST_SEL_DR = 4'h7,
    ST_EXIT2_IR = 4'h8,
    ST_EXIT1_IR = 4'h9,
    ST_SHIFT_IR = 4'ha,
    ST_PAUSE_IR = 4'hb,
    ST_IDLE = 4'hc,
    ST_UPDATE_IR = 4'hd,
    ST_CAPTURE_IR = 4'he,
    ST_RESET = 4'hf
  } sbst_state_t;

  function automatic sbst_state_t sbst_next(input sbst_state_t s, input logic tms);
    sbst_state_t n;
    n = s;
    unique case (s)
      ST_RESET: n = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: n = tms ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: n = tms ? ST_SEL_DR : ST_IDLE;
    endcase
    return n;
  endfunction

endpackage

// ===== verilog/sbst_tap_if.sv
`timescale 1ns/1ps
interface sbst_tap_if;
  import sbst_pkg::*;
  sbst_state_t state;
  modport ctl (output state);
  modport user (input state);
endinterface

// ===== verilog/sbst_tap_fsm.sv
`timescale 1ns/1ps
module sbst_tap_fsm
  import sbst_pkg::*;
(
  // Link clock and reset
  input wire logic tck,
  input wire logic tap_rst_n,
  // Steering input
  input wire logic tms,
  // State out
  sbst_tap_if.ctl tap
);

  sbst_state_t state_q;
  sbst_state_t state_d;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  // Five high TMS edges reach reset from any state
  always_comb
  begin
    state_d = sbst_next(state_q, tms); // R21 R5 R2
  end

  always_ff @(posedge tck)
  begin
    if (!tap_rst_n)
    begin
      state_q <= ST_RESET; // R6
    end
    else
    begin
      state_q <= state_d; // R1 R21
    end
  end

  assign tap.state = state_q;

endmodule

// ===== verilog/sbst_tap.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Sample on TCK rise, launch on fall
// R2 - TMS steers controller, pulled high when open
// R3 - TDI enters MSB, TDO shows LSB
// R4 - TDO driven only during shift states
// R5 - Five TMS-high edges reset test logic
// R6 - Power-up resets test logic, TDO floats; here the reset only reaches it over TCK edges
// R7 - Three-bit instruction, resets to identification
// R8 - Instruction capture loads 01 low bits
// R9 - Bypass is one flop, captured zero
// R10 - Boundary register holds 69 cells
// R11 - Capture pin ring, then shift it
// R12 - Identification captures hardwired 32-bit word
// R13 - Instruction takes effect at update only
// R14 - All-zero code samples and floats outputs
// R15 - Sample-floated samples and floats outputs
// R16 - No preload; data update acts as pause
// R17 - Master never loads reserved codes
// R18 - Never drive or preload memory pins
// R19 - Unused port: TCK low, TDO open
// R20 - Master keeps pins stable around capture
// R21 - Standard sixteen-state controller on TCK
// R22 - Instruction codes come from parameters; here the all-zero code is fixed in the package, not a parameter
module sbst_tap
  import sbst_pkg::*;
#(
  parameter logic [2:0] INS_IDENT = INS_IDENT_DEF,
  parameter logic [2:0] INS_SAMPLE_Z = INS_SAMPLE_Z_DEF,
  parameter logic [2:0] INS_SAMPLE = INS_SAMPLE_DEF,
  parameter logic [2:0] INS_BYPASS = INS_BYPASS_DEF,
  parameter logic [2:0] INS_RSVD_A = INS_RSVD_A_DEF,
  parameter logic [2:0] INS_RSVD_B = INS_RSVD_B_DEF,
  parameter logic [2:0] INS_RSVD_C = INS_RSVD_C_DEF,
  parameter logic [31:0] IDENT_WORD = IDENT_WORD_DEF
)
(
  // Memory clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Memory pin ring
  input wire logic [BSR_W-1:0] ring_pins,
  // Memory output float request, memory clock domain
  output logic mem_out_hiz
);

  // ----------------------------------------------------------------
  // Test-logic reset in the TCK domain
  // ----------------------------------------------------------------
  // Power-up reset is carried in from the memory side through two TCK
  // flops; a parked TCK never brings the port into its reset state.
  logic rst_meta_q;
  logic rst_sync_q;
  logic tap_rst_n;

  always_ff @(posedge tck)
  begin
    rst_meta_q <= rst_n;
    rst_sync_q <= rst_meta_q;
  end

  assign tap_rst_n = rst_sync_q; // R6

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  sbst_tap_if tap ();

  sbst_tap_fsm u_fsm (
    .tck(tck),
    .tap_rst_n(tap_rst_n),
    .tms(tms),
    .tap(tap)
  );

  sbst_state_t st;
  assign st = tap.state;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_sh_q;
  logic sel_bsr;
  logic sel_ident;
  logic sel_bypass;
  logic float_ins;

  function automatic logic is_sample_code(input logic [2:0] c, input logic [2:0] s,
                                          input logic [2:0] z);
    return (c == INS_FLOAT_SAMPLE_ALL0) || (c == s) || (c == z);
  endfunction

  always_comb
  begin
    sel_bsr = is_sample_code(ir_q, INS_SAMPLE, INS_SAMPLE_Z); // R11 R14 R15 R22
    sel_ident = (ir_q == INS_IDENT); // R12 R22
    // Reserved codes fall back to the short bypass path, so a stray
    // code still leaves a working chain. R17
    sel_bypass = !sel_bsr && !sel_ident;
    float_ins = (ir_q == INS_FLOAT_SAMPLE_ALL0) || (ir_q == INS_SAMPLE_Z); // R14 R15
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  always_ff @(posedge tck)
  begin
    if (!tap_rst_n)
    begin
      ir_sh_q <= IR_CAPTURE_VAL;
    end
    else
    begin
      unique case (st)
        ST_CAPTURE_IR:
        begin
          ir_sh_q <= IR_CAPTURE_VAL; // R8
        end
        ST_SHIFT_IR:
        begin
          ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]}; // R3 R13
        end
        default:
        begin
          ir_sh_q <= ir_sh_q;
        end
      endcase
    end
  end

  always_ff @(posedge tck)
  begin
    if (!tap_rst_n)
    begin
      ir_q <= INS_IDENT; // R7 R6
    end
    else if (st == ST_RESET)
    begin
      ir_q <= INS_IDENT; // R7 R5
    end
    else if (st == ST_UPDATE_IR)
    begin
      ir_q <= ir_sh_q; // R13
    end
  end

  // ----------------------------------------------------------------
  // Pin ring synchroniser
  // ----------------------------------------------------------------
  // Pins move on the fast memory clock; a bit caught mid-change is
  // resolved here but its value is still only as good as the master
  // made it by holding the pins steady. R20
  logic [BSR_W-1:0] ring_meta_q;
  logic [BSR_W-1:0] ring_sync_q;

  always_ff @(posedge tck)
  begin
    ring_meta_q <= ring_pins;
    ring_sync_q <= ring_meta_q;
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  logic [BSR_W-1:0] bsr_q;
  logic [ID_W-1:0] ident_q;
  logic bypass_q;

  // Boundary cells capture only; update is ignored, no preload. R16 R18
  always_ff @(posedge tck)
  begin
    if (!tap_rst_n)
    begin
      bsr_q <= '0;
    end
    else if (sel_bsr && st == ST_CAPTURE_DR)
    begin
      bsr_q <= ring_sync_q; // R11 R10
    end
    else if (sel_bsr && st == ST_SHIFT_DR)
    begin
      bsr_q <= {tdi, bsr_q[BSR_W-1:1]}; // R3 R11
    end
  end

  always_ff @(posedge tck)
  begin
    if (!tap_rst_n)
    begin
      ident_q <= IDENT_WORD;
    end
    else if (sel_ident && st == ST_CAPTURE_DR)
    begin
      ident_q <= IDENT_WORD; // R12
    end
    else if (sel_ident && st == ST_SHIFT_DR)
    begin
      ident_q <= {tdi, ident_q[ID_W-1:1]}; // R3 R12
    end
  end

  always_ff @(posedge tck)
  begin
    if (!tap_rst_n)
    begin
      bypass_q <= BYPASS_CAPTURE_VAL;
    end
    else if (sel_bypass && st == ST_CAPTURE_DR)
    begin
      bypass_q <= BYPASS_CAPTURE_VAL; // R9
    end
    else if (sel_bypass && st == ST_SHIFT_DR)
    begin
      bypass_q <= tdi; // R9 R3
    end
  end

  // ----------------------------------------------------------------
  // Serial output, launched on the falling edge
  // ----------------------------------------------------------------
  logic tdo_d;
  logic tdo_oe_d;
  logic tdo_q;
  logic tdo_oe_q;

  always_comb
  begin
    tdo_oe_d = (st == ST_SHIFT_DR) || (st == ST_SHIFT_IR); // R4
    if (st == ST_SHIFT_IR)
    begin
      tdo_d = ir_sh_q[0]; // R3
    end
    else if (sel_bsr)
    begin
      tdo_d = bsr_q[0]; // R3
    end
    else if (sel_ident)
    begin
      tdo_d = ident_q[0]; // R3
    end
    else
    begin
      tdo_d = bypass_q;
    end
  end

  always_ff @(negedge tck)
  begin
    if (!tap_rst_n)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0; // R6
    end
    else
    begin
      tdo_q <= tdo_d; // R1
      tdo_oe_q <= tdo_oe_d; // R1 R4
    end
  end

  // Enable is only reset on a TCK fall, so with TCK parked since power-up it is never forced low. R19
  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // ----------------------------------------------------------------
  // Output float request into the memory clock domain
  // ----------------------------------------------------------------
  // The only effect the port has on the memory; a test-logic reset
  // releases it and leaves reads and writes untouched. R5 R18
  logic float_tck_q;
  logic float_meta_q;
  logic float_sync_q;

  always_ff @(posedge tck)
  begin
    if (!tap_rst_n)
    begin
      float_tck_q <= 1'b0;
    end
    else
    begin
      float_tck_q <= float_ins; // R14 R15
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      float_meta_q <= 1'b0;
      float_sync_q <= 1'b0;
    end
    else
    begin
      float_meta_q <= float_tck_q;
      float_sync_q <= float_meta_q;
    end
  end

  assign mem_out_hiz = float_sync_q;

endmodule

// ===== testbench/sbst_tap_properties.sv
`timescale 1ns/1ps
module sbst_tap_properties
  import sbst_pkg::*;
(
  // Clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  // Test port
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  // Memory side
  input wire logic [BSR_W-1:0] ring_pins,
  input wire logic mem_out_hiz
);
  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  property p_oe_rise;
    @(posedge tck) disable iff (!rst_n)
      $rose(tdo_oe) |-> !$past(tms) && ($past(tms, 2) || $past(tms, 3));
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("tdo_oe rose off shift entry");
  property p_oe_hold;
    @(posedge tck) disable iff (!rst_n) tdo_oe && !tms |=> tdo_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("tdo_oe lost inside shift");
  property p_oe_drop;
    @(posedge tck) disable iff (!rst_n) tdo_oe && tms |=> !tdo_oe;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("tdo_oe kept after shift exit");
  property p_oe_fell;
    @(posedge tck) disable iff (!rst_n) $fell(tdo_oe) |-> $past(tms);
  endproperty
  a_oe_fell: assert property (p_oe_fell) else $error("tdo_oe fell without exit");
  property p_five_oe;
    @(posedge tck) disable iff (!rst_n) tms [*5] |=> !tdo_oe;
  endproperty
  a_five_oe: assert property (p_five_oe) else $error("tdo driven after tms reset");
  // Four more edges cover reset entry and the trip into the memory domain
  property p_five_hiz;
    @(posedge tck) disable iff (!rst_n) tms [*5] |-> ##4 !mem_out_hiz;
  endproperty
  a_five_hiz: assert property (p_five_hiz) else $error("float kept after tms reset");
  // ----------------------------------------------------------------
  // Memory side
  // ----------------------------------------------------------------
  property p_hiz_rst;
    @(posedge clk) !rst_n |=> !mem_out_hiz;
  endproperty
  a_hiz_rst: assert property (p_hiz_rst) else $error("float set during reset");
  // Float follows update or test-logic reset, never a shift in flight
  property p_hiz_quiet;
    @(posedge clk) disable iff (!rst_n) $changed(mem_out_hiz) |-> !tdo_oe;
  endproperty
  a_hiz_quiet: assert property (p_hiz_quiet) else $error("float moved while shifting");
  c_oe: cover property (@(posedge tck) disable iff (!rst_n) $rose(tdo_oe));
  c_hiz: cover property (@(posedge clk) disable iff (!rst_n) $rose(mem_out_hiz));
  c_five: cover property (@(posedge tck) disable iff (!rst_n) tms [*5]);
endmodule

bind sbst_tap sbst_tap_properties u_props (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_pins(ring_pins), .mem_out_hiz(mem_out_hiz));

// ===== testbench/sbst_scan_master.sv
`timescale 1ns/1ps
module sbst_scan_master
  import sbst_pkg::*;
(
  // Scan lines out
  output logic tck,
  output logic tms,
  output logic tdi,
  // Scan line in
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic last_q;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    last_q = 1'b0;
  end
  // ----------------------------------------------------------------
  // One tck period; tck stands low between calls
  // ----------------------------------------------------------------
  task automatic bit1(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    #16;
    // Released line reads inverted, so a float never looks valid
    o = tdo_oe ? tdo : ~last_q;
    last_q = o;
    tck <= 1'b1;
    #16;
    tck <= 1'b0;
  endtask
  task automatic idle(input int n);
    logic o;
    repeat (n) bit1(1'b0, 1'b0, o);
  endtask
  // Exactly five high edges, then two idle edges so the float request settles
  task automatic tms_reset();
    logic o;
    repeat (TMS_RESET_EDGES) bit1(1'b1, 1'b0, o);
    idle(2);
  endtask
  task automatic shift(input logic [71:0] din, input int n, output logic [71:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      bit1(i == n - 1, din[i], o);
      dout[i] = o;
    end
  endtask
  // Only implemented codes are loaded
  task automatic ir(input logic [2:0] code, output logic [71:0] cap);
    logic o;
    bit1(1'b1, 1'b0, o);
    bit1(1'b1, 1'b0, o);
    idle(2);
    shift({69'h0, code}, IR_W, cap);
    bit1(1'b1, 1'b0, o);
    idle(2);
  endtask
  task automatic dr(input logic [71:0] din, output logic [71:0] dout);
    logic o;
    bit1(1'b1, 1'b0, o);
    idle(2);
    shift(din, 72, dout);
    bit1(1'b1, 1'b0, o);
    idle(1);
  endtask
endmodule

// ===== testbench/sbst_tap_tb.sv
`timescale 1ns/1ps
module sbst_tap_tb;
  import sbst_pkg::*;
  localparam logic [71:0] DIN = 72'hc3_5a5a_0ff0_1234_9876;
  logic clk;
  logic rst_n;
  logic [BSR_W-1:0] ring_pins;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic mem_out_hiz;
  int fail_count;
  int n_compared;
  always #12.5 clk = ~clk;
  sbst_tap u_dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .ring_pins(ring_pins), .mem_out_hiz(mem_out_hiz));
  sbst_scan_master u_mst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Kind 0 identity, 1 pin ring, 2 single bypass flop
  function automatic logic [71:0] exp_dr(input int kind, input logic [68:0] ring);
    if (kind == 0)
      return {DIN[39:0], IDENT_WORD_DEF};
    if (kind == 1)
      return {DIN[2:0], ring};
    return {DIN[70:0], BYPASS_CAPTURE_VAL};
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    logic [71:0] got;
    check({71'h0, tdo_oe}, 72'h0);
    u_mst.dr(DIN, got);
    check(got, exp_dr(0, ring_pins));
  endtask
  task automatic t_code(input logic [2:0] code, input int kind, input logic hiz);
    logic [71:0] got;
    u_mst.ir(code, got);
    check(got, {69'h0, IR_CAPTURE_VAL});
    repeat (3) @(posedge clk);
    check({71'h0, mem_out_hiz}, {71'h0, hiz});
    ring_pins <= ~ring_pins;
    // Two idle periods let the ring settle through the sync flops
    u_mst.idle(2);
    u_mst.dr(DIN, got);
    check(got, exp_dr(kind, ring_pins));
  endtask
  task automatic t_tms_reset();
    logic [71:0] got;
    logic o;
    u_mst.ir(INS_SAMPLE_Z_DEF, got);
    // Park in data shift, farthest from reset, so all five edges count
    u_mst.bit1(1'b1, 1'b0, o);
    u_mst.idle(2);
    u_mst.tms_reset();
    repeat (3) @(posedge clk);
    check({71'h0, mem_out_hiz}, 72'h0);
    u_mst.dr(DIN, got);
    check(got, exp_dr(0, ring_pins));
  endtask
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ring_pins = 69'h1_2345_6789_abcd_ef01;
    fail_count = 0;
    n_compared = 0;
    fork
      repeat (5) @(posedge clk);
      u_mst.idle(3);
    join
    rst_n <= 1'b1;
    u_mst.idle(3);
    t_power();
    t_code(INS_SAMPLE_DEF, 1, 1'b0);
    t_code(INS_FLOAT_SAMPLE_ALL0, 1, 1'b1);
    t_code(INS_BYPASS_DEF, 2, 1'b0);
    t_code(INS_SAMPLE_Z_DEF, 1, 1'b1);
    t_code(INS_IDENT_DEF, 0, 1'b0);
    t_tms_reset();
    report_and_stop();
  end
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule
